/* File: otr_pkg.sv */
// Purpose: Shared constants, types and states of the overtemperature response block
// Assumes: Temperatures inside the block are signed fixed point with four fraction bits
// Notes: Command codes double as the register addresses on the command port
package otr_pkg;

	// --------------------------------------------------
	// Command codes
	// --------------------------------------------------
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03; // Send-byte clear of all flags
	localparam logic [7:0] CMD_FAULT_ACTION = 8'h50; // Response byte
	localparam logic [7:0] CMD_WARN_THRESHOLD = 8'h51; // Warning threshold word

	// --------------------------------------------------
	// Field layout
	// --------------------------------------------------
	localparam int ACTION_HI = 7;
	localparam int ACTION_LO = 6;
	localparam int RETRY_HI = 5;
	localparam int RETRY_LO = 3;
	localparam int DELAY_HI = 2;
	localparam int DELAY_LO = 0;
	localparam int EXP_HI = 15;
	localparam int EXP_LO = 11;
	localparam int MAN_HI = 10;
	localparam int MAN_LO = 0;

	// Fault action codes
	localparam logic [1:0] ACT_IGNORE = 2'h0;
	localparam logic [1:0] ACT_DELAYED = 2'h1;
	localparam logic [1:0] ACT_IMMEDIATE = 2'h2;
	localparam logic [1:0] ACT_COOL = 2'h3;
	// Retry and delay codes
	localparam logic [2:0] RETRY_NONE = 3'h0;
	localparam logic [2:0] RETRY_FOREVER = 3'h7;
	localparam logic [2:0] DELAY_ZERO = 3'h0;

	// --------------------------------------------------
	// Reset values (stand in for the stored defaults)
	// --------------------------------------------------
	localparam logic [7:0] FAULT_ACTION_RESET = 8'h80;
	localparam logic [15:0] WARN_THRESHOLD_RESET = 16'h0064;

	// --------------------------------------------------
	// Temperatures
	// --------------------------------------------------
	localparam int TEMP_FRAC_BITS = 4;
	localparam int TEMP_DISABLE_DEGC = 255;
	localparam int HYSTERESIS_DEGC = 20;
	localparam int NVM_MIN_DEGC = 0;
	localparam int NVM_MAX_DEGC = 160;
	localparam int TEMP_DISABLE_Q = TEMP_DISABLE_DEGC * (1 << TEMP_FRAC_BITS);
	localparam int HYSTERESIS_Q = HYSTERESIS_DEGC * (1 << TEMP_FRAC_BITS);
	localparam int ROUND_HALF_Q = (1 << TEMP_FRAC_BITS) / 2;

	// --------------------------------------------------
	// Timing
	// --------------------------------------------------
	localparam int CLOCK_MHZ = 200;
	localparam int DELAY_STEP_MS = 10;
	localparam int DELAY_STEP_CYCLES = DELAY_STEP_MS * CLOCK_MHZ * 1000;

	// --------------------------------------------------
	// Carriers
	// --------------------------------------------------
	typedef struct packed {
		logic valid; // One-cycle command strobe
		logic write; // High for write, low for read
		logic word; // High for word transfer, low for byte
		logic [7:0] code; // Command code
		logic [15:0] data; // Write data, byte in the low bits
	} otr_cmd_t;

	typedef struct packed {
		logic valid; // One-cycle answer strobe
		logic error; // Command refused
		logic [15:0] data; // Read data
	} otr_resp_t;

	typedef struct packed {
		logic tempSummary;
		logic overheatFaultFlag;
		logic overheatWarningFlag;
		logic invalidData;
		logic unsupportedCmd;
	} otr_status_t;

	typedef enum logic [6:0] {
		ST_OFF = 7'h01,
		ST_START = 7'h02,
		ST_RUN = 7'h04,
		ST_DELAY = 7'h08,
		ST_COOL = 7'h10,
		ST_RESTART_WAIT_PERIOD = 7'h20,
		ST_LATCHED = 7'h40
	} otr_state_t;

endpackage : otr_pkg

/* File: otr_fault_response.sv */
// Purpose: Overtemperature detection, flags and shutdown/restart sequencing
// Assumes: Telemetry samples, limits and power-stage handshakes run on clock
// Notes: Command port runs on linkClock and crosses by a toggle handshake
`timescale 1ns/1ps

// Contract
// - Response byte at 50h, byte access, live
// - Fault trip sets summary, fault flag, notify
// - Warning trip sets summary, warning flag, notify
// - Fault releases below warning threshold
// - Otherwise release twenty degrees below fault
// - Ignore action keeps running, flags set
// - Delayed action waits 10ms per step
// - Immediate action shuts down then retries
// - Cool action waits for release, retries
// - Retry zero latches, 1-6 limited attempts
// - Retry seven retries until off or success
// - Hot attempts hidden but still counted
// - Delay zero immediate; restart_wait_period multiples rise
// - Bad writes refused, status set, notify
// - Clear in cool mode may stick
// - Fault at enable blocks start-up
// - Warning word: linear exponent and mantissa
// - Restore rounds threshold to whole degrees
// - Threshold 255 disables warning
// - Fault limit 255 disables comparison
module otr_fault_response import otr_pkg::*; #(
	parameter int DELAY_STEP = DELAY_STEP_CYCLES, // Cycles per delay step
	parameter int RISE_WIDTH = 24 // Width of the rise-time count
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic linkClock,
	input wire otr_cmd_t linkCmd,
	output logic linkCmdReady,
	output otr_resp_t linkResp,
	input wire logic tempSampleValid,
	input wire logic signed [15:0] tempSample,
	input wire logic [15:0] faultLimitWord,
	input wire logic [RISE_WIDTH-1:0] tonRiseCycles,
	input wire logic enableRequest,
	input wire logic startupDone,
	input wire logic nvmRestore,
	output logic powerStageOn,
	output otr_status_t status,
	output logic hostNotify
);

	// --------------------------------------------------
	// Elaboration checks
	// --------------------------------------------------
	if (DELAY_STEP < 1 || RISE_WIDTH < 1 || RISE_WIDTH > 28) begin : g_bad_param
		$error("otr_fault_response: parameter out of range");
	end

	// Linear word to signed degrees with four fraction bits, by plain shifts with no saturation
	function automatic logic signed [31:0] otr_lin_to_q(input logic [15:0] w);
		logic signed [4:0] e;
		logic signed [31:0] m;
		int sh;
		e = w[EXP_HI:EXP_LO];
		m = 32'(signed'(w[MAN_HI:MAN_LO]));
		sh = int'(e) + TEMP_FRAC_BITS;
		if (sh >= 0) begin
			otr_lin_to_q = m <<< sh;
		end else begin
			otr_lin_to_q = m >>> (-sh);
		end
	endfunction : otr_lin_to_q

	// --------------------------------------------------
	// Link domain: take a command, hold it, wait for the answer
	// --------------------------------------------------
	otr_cmd_t heldCmd; // Stable from take until answer
	logic linkBusy; // A command is in flight
	logic reqToggle; // Flips once per command
	logic ackSyncA; // First stage, read only by ackSyncB
	logic ackSyncB;
	logic ackSeen;
	logic coreAck; // Core domain answer toggle
	logic coreRespError;
	logic [15:0] coreRespData;
	wire takeCmd = linkCmd.valid & ~linkBusy;
	wire ackEdge = ackSyncB ^ ackSeen;
	wire next_linkBusy = takeCmd | (linkBusy & ~ackEdge);

	// Requests while busy are dropped; ready tells the sender
	always_ff @(posedge linkClock or negedge rst_b) begin
		if (!rst_b) begin
			heldCmd <= '0;
			linkBusy <= 1'b0;
			reqToggle <= 1'b0;
			linkCmdReady <= 1'b0;
		end else begin
			if (takeCmd) begin
				heldCmd <= linkCmd;
				reqToggle <= ~reqToggle;
			end
			linkBusy <= next_linkBusy;
			linkCmdReady <= ~next_linkBusy;
		end
	end

	// Answer strobe; core data is stable while the ack travels
	always_ff @(posedge linkClock or negedge rst_b) begin
		if (!rst_b) begin
			ackSyncA <= 1'b0;
			ackSyncB <= 1'b0;
			ackSeen <= 1'b0;
			linkResp <= '0;
		end else begin
			ackSyncA <= coreAck;
			ackSyncB <= ackSyncA;
			ackSeen <= ackSyncB;
			linkResp.valid <= ackEdge;
			if (ackEdge) begin
				linkResp.error <= coreRespError;
				linkResp.data <= coreRespData;
			end
		end
	end

	a_link_answer: assert property (@(posedge linkClock) disable iff (!rst_b)
		takeCmd |-> ##[3:40] linkResp.valid)
		else $error("command not answered in time");

	// --------------------------------------------------
	// Core domain: command decode
	// --------------------------------------------------
	logic reqSyncA; // First stage, read only by reqSyncB
	logic reqSyncB;
	logic reqSeen;
	logic [7:0] faultAction;
	logic [15:0] warnWord;
	wire reqEdge = reqSyncB ^ reqSeen;
	wire isAction = heldCmd.code == CMD_FAULT_ACTION;
	wire isWarn = heldCmd.code == CMD_WARN_THRESHOLD;
	wire isClear = heldCmd.code == CMD_CLEAR_FAULTS;
	wire cmdKnown = isAction | isWarn | isClear;
	// Byte commands must be byte sized, the word command word sized
	wire sizeOk = isWarn ? heldCmd.word : ~heldCmd.word;
	wire signed [31:0] newWarnQ = otr_lin_to_q(heldCmd.data);
	wire warnValueOk = (newWarnQ >= 0) && (newWarnQ <= TEMP_DISABLE_Q);
	wire cmdBad = reqEdge & cmdKnown & (~sizeOk | (isWarn & heldCmd.write & ~warnValueOk)
		| (isClear & ~heldCmd.write));
	wire cmdUnknown = reqEdge & ~cmdKnown;
	wire cmdGood = reqEdge & cmdKnown & ~cmdBad & heldCmd.write;
	wire actionWrite = cmdGood & isAction;
	wire warnWrite = cmdGood & isWarn;
	wire clearNow = cmdGood & isClear;
	wire [15:0] readData = isAction ? {8'h00, faultAction} : (isWarn ? warnWord : 16'h0000);

	// Request sync and answer capture
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			reqSyncA <= 1'b0;
			reqSyncB <= 1'b0;
			reqSeen <= 1'b0;
			coreAck <= 1'b0;
			coreRespError <= 1'b0;
			coreRespData <= 16'h0000;
		end else begin
			reqSyncA <= reqToggle;
			reqSyncB <= reqSyncA;
			reqSeen <= reqSyncB;
			if (reqEdge) begin
				coreAck <= ~coreAck;
				coreRespError <= cmdBad | cmdUnknown;
				coreRespData <= heldCmd.write ? 16'h0000 : readData;
			end
		end
	end

	// --------------------------------------------------
	// Registers; restore rounds to the stored whole-degree grid
	// --------------------------------------------------
	wire signed [31:0] warnQ = otr_lin_to_q(warnWord);
	wire signed [31:0] roundedDeg = (warnQ + ROUND_HALF_Q) >>> TEMP_FRAC_BITS;
	wire signed [31:0] clampedDeg = (roundedDeg < NVM_MIN_DEGC) ? NVM_MIN_DEGC :
		((roundedDeg > NVM_MAX_DEGC) ? NVM_MAX_DEGC : roundedDeg);
	wire [15:0] restoredWord = {5'h00, clampedDeg[MAN_HI:MAN_LO]};

	// New values act on the next sample with no re-arm needed
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			faultAction <= FAULT_ACTION_RESET;
			warnWord <= WARN_THRESHOLD_RESET;
		end else begin
			if (actionWrite) begin
				faultAction <= heldCmd.data[7:0];
			end
			if (warnWrite) begin
				warnWord <= heldCmd.data;
			end else if (nvmRestore) begin
				warnWord <= restoredWord;
			end
		end
	end

	// Field views
	wire [1:0] faultActionSelect = faultAction[ACTION_HI:ACTION_LO];
	wire [2:0] restartAttemptCount = faultAction[RETRY_HI:RETRY_LO];
	wire [2:0] shutdownDelaySelect = faultAction[DELAY_HI:DELAY_LO];
	wire retryForever = restartAttemptCount == RETRY_FOREVER;

	// --------------------------------------------------
	// Comparison against both thresholds on every sample
	// --------------------------------------------------
	wire signed [31:0] faultQ = otr_lin_to_q(faultLimitWord);
	wire signed [31:0] sampleQ = 32'(tempSample);
	wire faultEnabled = faultQ != TEMP_DISABLE_Q;
	wire warnEnabled = warnQ != TEMP_DISABLE_Q;
	// A disabled or too-high warning cannot give hysteresis
	wire useDefaultHyst = ~warnEnabled | (warnQ > faultQ);
	wire signed [31:0] releaseQ = useDefaultHyst ? (faultQ - HYSTERESIS_Q) : warnQ;
	wire tripEvt = tempSampleValid & faultEnabled & (sampleQ > faultQ);
	wire warnEvt = tempSampleValid & warnEnabled & (sampleQ > warnQ);
	wire releaseEvt = tempSampleValid & ~tripEvt & (sampleQ < releaseQ);
	logic faultActive; // Latched fault condition

	// --------------------------------------------------
	// Flags: a set in the cycle of a clear wins
	// --------------------------------------------------
	otr_status_t next_status;
	always_comb begin
		next_status.overheatFaultFlag = tripEvt | (status.overheatFaultFlag & ~clearNow);
		next_status.overheatWarningFlag = warnEvt
			| (status.overheatWarningFlag & ~clearNow);
		next_status.tempSummary = tripEvt | warnEvt | (status.tempSummary & ~clearNow);
		next_status.invalidData = cmdBad | (status.invalidData & ~clearNow);
		next_status.unsupportedCmd = cmdUnknown | (status.unsupportedCmd & ~clearNow);
	end

	// Clearing drops the latch too, so cool mode may wait for a new trip
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			status <= '0;
			hostNotify <= 1'b0;
			faultActive <= 1'b0;
		end else begin
			status <= next_status;
			hostNotify <= |next_status;
			faultActive <= tripEvt | (faultActive & ~releaseEvt & ~clearNow);
		end
	end

	a_trip_flags: assert property (@(posedge clock) disable iff (!rst_b)
		tripEvt |=> status.overheatFaultFlag && status.tempSummary && hostNotify)
		else $error("fault trip did not raise flags");
	a_warn_flags: assert property (@(posedge clock) disable iff (!rst_b)
		warnEvt |=> status.overheatWarningFlag && status.tempSummary && hostNotify)
		else $error("warning trip did not raise flags");
	a_fault_release: assert property (@(posedge clock) disable iff (!rst_b)
		(tempSampleValid && sampleQ < releaseQ && sampleQ <= faultQ) |=> !faultActive)
		else $error("fault not released below threshold");
	a_default_hyst: assert property (@(posedge clock) disable iff (!rst_b)
		(!warnEnabled || warnQ > faultQ) |-> (releaseQ == faultQ - HYSTERESIS_Q))
		else $error("default hysteresis not applied");
	a_bad_write: assert property (@(posedge clock) disable iff (!rst_b)
		cmdBad |=> status.invalidData && hostNotify && $stable(warnWord))
		else $error("invalid write not refused");
	a_warn_off: assert property (@(posedge clock) disable iff (!rst_b)
		(!warnEnabled && !status.overheatWarningFlag) |=> !status.overheatWarningFlag)
		else $error("disabled warning still raised");

	// --------------------------------------------------
	// Sequencer: shutdown delay, restart wait and attempts
	// --------------------------------------------------
	otr_state_t state;
	otr_state_t next_state;
	logic [31:0] waitCount; // Counts down to zero
	logic [2:0] attemptsLeft;
	logic [2:0] next_attemptsLeft;
	logic cntLoad;
	logic [31:0] cntValue;
	wire cntDone = waitCount == 32'h0;
	// Delay step zero still gives one rise time of restart wait
	wire [2:0] hiccupMult = (shutdownDelaySelect == DELAY_ZERO) ? 3'h1 : shutdownDelaySelect;
	wire [31:0] restartWaitPeriod = 32'(hiccupMult) * 32'(tonRiseCycles);
	wire [31:0] delayCycles = 32'(shutdownDelaySelect) * 32'(DELAY_STEP);
	wire [2:0] attemptsAfter = retryForever ? attemptsLeft : attemptsLeft - 3'h1;
	wire noRetry = restartAttemptCount == RETRY_NONE;

	// Next state; host off always wins and stops retrying
	always_comb begin
		next_state = state;
		next_attemptsLeft = attemptsLeft;
		cntLoad = 1'b0;
		cntValue = restartWaitPeriod;
		unique case (state)
			ST_OFF: begin
				// A standing fault blocks start whatever the action
				if (enableRequest && !faultActive) begin
					next_state = ST_START;
					next_attemptsLeft = restartAttemptCount;
				end
			end
			ST_START: begin
				if (!enableRequest) begin
					next_state = ST_OFF;
				end else if (faultActive && faultActionSelect != ACT_IGNORE) begin
					cntLoad = 1'b1;
					next_state = (attemptsLeft == 3'h0 && !retryForever) ? ST_LATCHED : ST_RESTART_WAIT_PERIOD;
				end else if (startupDone) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				next_attemptsLeft = restartAttemptCount;
				cntLoad = 1'b1;
				if (!enableRequest) begin
					next_state = ST_OFF;
				end else if (faultActive) begin
					unique case (faultActionSelect)
						ACT_IGNORE: next_state = ST_RUN;
						ACT_DELAYED: begin
							cntValue = delayCycles;
							if (shutdownDelaySelect == DELAY_ZERO) begin
								next_state = noRetry ? ST_LATCHED : ST_RESTART_WAIT_PERIOD;
								cntValue = restartWaitPeriod;
							end else begin
								next_state = ST_DELAY;
							end
						end
						ACT_IMMEDIATE: next_state = noRetry ? ST_LATCHED : ST_RESTART_WAIT_PERIOD;
						ACT_COOL: next_state = ST_COOL;
					endcase
				end
			end
			ST_DELAY: begin
				if (!enableRequest) begin
					next_state = ST_OFF;
				end else if (!faultActive) begin
					next_state = ST_RUN;
				end else if (cntDone) begin
					cntLoad = 1'b1;
					next_state = noRetry ? ST_LATCHED : ST_RESTART_WAIT_PERIOD;
				end
			end
			ST_COOL: begin
				// Exits only on host off or a release; a clear while warm can leave it parked
				if (!enableRequest) begin
					next_state = ST_OFF;
				end else if (releaseEvt && faultActive) begin
					cntLoad = 1'b1;
					next_attemptsLeft = restartAttemptCount;
					next_state = noRetry ? ST_LATCHED : ST_RESTART_WAIT_PERIOD;
				end
			end
			ST_RESTART_WAIT_PERIOD: begin
				if (!enableRequest) begin
					next_state = ST_OFF;
				end else if (cntDone) begin
					next_attemptsLeft = attemptsAfter;
					if (!faultActive) begin
						next_state = ST_START;
					end else if (attemptsAfter == 3'h0 && !retryForever) begin
						next_state = ST_LATCHED;
					end else begin
						cntLoad = 1'b1;
					end
				end
			end
			ST_LATCHED: begin
				if (!enableRequest) begin
					next_state = ST_OFF;
				end
			end
			default: next_state = ST_OFF;
		endcase
	end

	// State, attempts and the shared wait counter
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state <= ST_OFF;
			attemptsLeft <= 3'h0;
			waitCount <= 32'h0;
			powerStageOn <= 1'b0;
		end else begin
			state <= next_state;
			attemptsLeft <= next_attemptsLeft;
			if (cntLoad) begin
				waitCount <= cntValue;
			end else if (!cntDone) begin
				waitCount <= waitCount - 32'h1;
			end
			// Hidden attempts never raise the stage
			powerStageOn <= (next_state == ST_START) || (next_state == ST_RUN)
				|| (next_state == ST_DELAY);
		end
	end

	a_ignore_runs: assert property (@(posedge clock) disable iff (!rst_b)
		(state == ST_RUN && enableRequest && faultActionSelect == ACT_IGNORE)
		|=> state == ST_RUN && powerStageOn)
		else $error("ignore action interrupted output");
	a_immediate_off: assert property (@(posedge clock) disable iff (!rst_b)
		(state == ST_RUN && enableRequest && faultActive
		&& faultActionSelect == ACT_IMMEDIATE) |=> !powerStageOn)
		else $error("immediate shutdown missed");
	a_latch_zero: assert property (@(posedge clock) disable iff (!rst_b)
		(state == ST_RUN && enableRequest && faultActive && noRetry
		&& faultActionSelect == ACT_IMMEDIATE) |=> state == ST_LATCHED)
		else $error("retry zero did not latch off");
	a_start_block: assert property (@(posedge clock) disable iff (!rst_b)
		(state == ST_OFF && faultActive) |=> state == ST_OFF && !powerStageOn)
		else $error("started with fault present");

endmodule : otr_fault_response

/* File: otr_host_model.sv */
// Purpose: Command-port host model that issues reads, writes and send-byte commands
// Assumes: One command in flight; data byte sits in the low bits of the data field
// Notes: Drives on the falling link edge so the design samples settled values
`timescale 1ns/1ps
module otr_host_model import otr_pkg::*; (
	input wire logic linkClock,
	input wire logic rst_b,
	input wire logic linkCmdReady,
	input wire otr_resp_t linkResp,
	output otr_cmd_t linkCmd
);
	// --------------------------------------------------
	// Idle bus
	// --------------------------------------------------
	initial begin
		linkCmd = '0;
	end

	// One whole transfer: wait for ready, strobe once, wait for the answer strobe
	task automatic xfer(input logic wr, input logic wd, input logic [7:0] code,
		input logic [15:0] wdata, output logic [15:0] rdata, output logic err);
		int n;
		n = 0;
		@(negedge linkClock);
		// Bounded wait so a stuck ready cannot hang the run
		while (linkCmdReady !== 1'b1 && n < 100) begin
			@(negedge linkClock);
			n++;
		end
		// Byte codes carry the value in the low byte, word codes in all 16 bits
		linkCmd <= '{valid: 1'b1, write: wr, word: wd, code: code, data: wdata};
		@(negedge linkClock);
		// Released data shows the inverse so a stale value is never mistaken for live
		linkCmd <= '{valid: 1'b0, write: ~wr, word: ~wd, code: ~code, data: ~wdata};
		n = 0;
		// Answer strobe stands one link cycle; look at it mid-cycle
		while (linkResp.valid !== 1'b1 && n < 60) begin
			@(negedge linkClock);
			n++;
		end
		rdata = linkResp.data;
		err = (n < 60) ? linkResp.error : 1'bx;
	endtask : xfer
endmodule : otr_host_model

/* File: overtemp_fault_response_tb_top.sv */
// Purpose: Self-checking bench for the overtemperature response block
// Assumes: Fault limit 120 degC until the last test sets 255 degC, rise time 10 cycles, delay step 20 cycles
// Notes: Temperatures are degC times 16 on the sample port
`timescale 1ns/1ps
module overtemp_fault_response_tb_top import otr_pkg::*;;
	// --------------------------------------------------
	// Signals
	// --------------------------------------------------
	logic clock, rst_b, linkClock, linkCmdReady;
	otr_cmd_t linkCmd;
	otr_resp_t linkResp;
	logic tempSampleValid, enableRequest, startupDone, nvmRestore, powerStageOn, hostNotify;
	logic signed [15:0] tempSample;
	logic [15:0] faultLimitWord, rd;
	logic [23:0] tonRiseCycles;
	otr_status_t status;
	logic er;
	int failures = 0;
	int testsRun = 0;
	localparam logic [15:0] HOT = 16'h0820; // 130 degC
	localparam logic [15:0] WARM = 16'h0690; // 105 degC
	localparam logic [15:0] COOL = 16'h05a0; // 90 degC

	// Core clock, 200 MHz
	initial clock = 1'b0;
	always #2.5 clock = ~clock;
	// Link clock, 12 ns, offset so the two never line up
	initial begin
		linkClock = 1'b0;
		#1.7;
		forever #6 linkClock = ~linkClock;
	end

	otr_fault_response #(.DELAY_STEP(20), .RISE_WIDTH(24)) dut (.clock(clock), .rst_b(rst_b),
		.linkClock(linkClock), .linkCmd(linkCmd), .linkCmdReady(linkCmdReady),
		.linkResp(linkResp), .tempSampleValid(tempSampleValid), .tempSample(tempSample),
		.faultLimitWord(faultLimitWord), .tonRiseCycles(tonRiseCycles),
		.enableRequest(enableRequest), .startupDone(startupDone), .nvmRestore(nvmRestore),
		.powerStageOn(powerStageOn), .status(status), .hostNotify(hostNotify));
	otr_host_model host (.linkClock(linkClock), .rst_b(rst_b), .linkCmdReady(linkCmdReady),
		.linkResp(linkResp), .linkCmd(linkCmd));

	// --------------------------------------------------
	// Helpers
	// --------------------------------------------------
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		testsRun++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	// One telemetry sample pulse
	task automatic sample(input logic [15:0] t);
		@(negedge clock);
		tempSample = t;
		tempSampleValid = 1'b1;
		@(negedge clock);
		tempSampleValid = 1'b0;
	endtask : sample

	// Wait a bounded span for the power stage to reach a level
	task automatic wait_on(input logic exp, input int span, input string what);
		int n;
		n = 0;
		while (powerStageOn !== exp && n < span) begin
			@(negedge clock);
			n++;
		end
		check(powerStageOn, exp, what);
	endtask : wait_on

	// Off, cool, clear, then a clean start-up under a new response byte
	task automatic bring_up(input logic [7:0] action);
		enableRequest = 1'b0;
		sample(COOL);
		host.xfer(1'b1, 1'b0, CMD_FAULT_ACTION, {8'h00, action}, rd, er);
		host.xfer(1'b1, 1'b0, CMD_CLEAR_FAULTS, 16'h0000, rd, er);
		repeat (3) @(negedge clock);
		enableRequest = 1'b1;
		repeat (4) @(negedge clock);
		startupDone = 1'b1;
		@(negedge clock);
		startupDone = 1'b0;
		wait_on(1'b1, 20, "start-up");
	endtask : bring_up

	// Verdict and end of run
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", testsRun, failures);
		if (failures == 0 && testsRun > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : wrap_up

	// Watchdog well beyond the expected few microseconds of traffic
	initial begin
		#200000;
		failures++;
		wrap_up();
	end

	// --------------------------------------------------
	// Tests
	// --------------------------------------------------
	initial begin
		rst_b = 1'b0;
		tempSampleValid = 1'b0;
		tempSample = COOL;
		faultLimitWord = 16'h0078; // 120 degC, above any start-up temperature here
		tonRiseCycles = 24'd10;
		enableRequest = 1'b0;
		startupDone = 1'b0;
		nvmRestore = 1'b0;
		// Async reset clears both domains; no link edge is needed for it
		repeat (2) @(negedge clock);
		rst_b = 1'b1;
		repeat (4) @(negedge linkClock);
		// Register access, refusals and restore rounding
		host.xfer(1'b0, 1'b0, CMD_FAULT_ACTION, 16'h0000, rd, er);
		check(rd, 16'h0080, "action reset");
		host.xfer(1'b0, 1'b1, CMD_WARN_THRESHOLD, 16'h0000, rd, er);
		check(rd, 16'h0064, "warn reset");
		host.xfer(1'b1, 1'b1, CMD_FAULT_ACTION, 16'h00c8, rd, er);
		check({15'h0, er}, 16'h0001, "word write to byte");
		host.xfer(1'b1, 1'b1, CMD_WARN_THRESHOLD, 16'h012c, rd, er);
		check({15'h0, er}, 16'h0001, "warn 300 degC");
		check({15'h0, status.invalidData}, 16'h0001, "invalid data flag");
		host.xfer(1'b0, 1'b0, 8'h7e, 16'h0000, rd, er);
		check({15'h0, status.unsupportedCmd}, 16'h0001, "unsupported flag");
		host.xfer(1'b1, 1'b1, CMD_WARN_THRESHOLD, 16'hf191, rd, er);
		host.xfer(1'b0, 1'b1, CMD_WARN_THRESHOLD, 16'h0000, rd, er);
		check(rd, 16'hf191, "warn full resolution");
		@(negedge clock);
		nvmRestore = 1'b1;
		@(negedge clock);
		nvmRestore = 1'b0;
		host.xfer(1'b0, 1'b1, CMD_WARN_THRESHOLD, 16'h0000, rd, er);
		check(rd, 16'h0064, "restore rounding");
		$display("test registers done");
		// Ignore action: flags rise, output keeps running
		bring_up(8'h00);
		check({15'h0, hostNotify}, 16'h0000, "clear faults");
		sample(WARM);
		check({13'h0, status.tempSummary, status.overheatWarningFlag, hostNotify}, 16'h0007,
			"warning flags");
		sample(HOT);
		check({15'h0, status.overheatFaultFlag}, 16'h0001, "fault flag");
		repeat (30) @(negedge clock);
		check({15'h0, powerStageOn}, 16'h0001, "ignore keeps running");
		enableRequest = 1'b0;
		repeat (3) @(negedge clock);
		enableRequest = 1'b1;
		repeat (10) @(negedge clock);
		check({15'h0, powerStageOn}, 16'h0000, "fault at enable");
		$display("test ignore done");
		// Immediate shutdown, no retry: latched off
		bring_up(8'h80);
		sample(HOT);
		wait_on(1'b0, 3, "immediate off");
		sample(COOL);
		repeat (60) @(negedge clock);
		check({15'h0, powerStageOn}, 16'h0000, "latched off");
		// Delayed shutdown of one 20-cycle step
		bring_up(8'h41);
		sample(HOT);
		repeat (10) @(negedge clock);
		check({15'h0, powerStageOn}, 16'h0001, "still in delay");
		wait_on(1'b0, 15, "delay expiry");
		// Immediate, two tries: both fall in the heat, so the count runs out
		bring_up(8'h90);
		sample(HOT);
		repeat (30) @(negedge clock);
		sample(COOL);
		repeat (30) @(negedge clock);
		check({15'h0, powerStageOn}, 16'h0000, "hot attempts counted");
		// Retry seven: hidden attempts go on until the heat is gone
		bring_up(8'hb8);
		sample(HOT);
		repeat (60) @(negedge clock);
		check({15'h0, powerStageOn}, 16'h0000, "hot attempts hidden");
		sample(COOL);
		wait_on(1'b1, 30, "retry seven restarts");
		$display("test shutdown done");
		// Cool-down action, one retry, restart_wait_period of two rise times
		bring_up(8'hca);
		sample(HOT);
		wait_on(1'b0, 3, "cool off");
		sample(WARM);
		repeat (40) @(negedge clock);
		check({15'h0, powerStageOn}, 16'h0000, "above warning stays off");
		sample(COOL);
		repeat (8) @(negedge clock);
		check({15'h0, powerStageOn}, 16'h0000, "restart_wait_period wait");
		wait_on(1'b1, 60, "restart after cool");
		// Warning disabled: release falls back to 100 degC
		host.xfer(1'b1, 1'b1, CMD_WARN_THRESHOLD, 16'h00ff, rd, er);
		bring_up(8'hc8);
		sample(HOT);
		wait_on(1'b0, 3, "cool off again");
		check({15'h0, status.overheatWarningFlag}, 16'h0000, "warning disabled");
		sample(16'h0650);
		repeat (40) @(negedge clock);
		check({15'h0, powerStageOn}, 16'h0000, "101 degC holds fault");
		sample(16'h0630);
		wait_on(1'b1, 60, "99 degC releases");
		// Both limits at 255 degC: nothing trips even at 256 degC
		host.xfer(1'b1, 1'b0, CMD_CLEAR_FAULTS, 16'h0000, rd, er);
		faultLimitWord = 16'h00ff;
		sample(16'h1000);
		check({14'h0, status.overheatFaultFlag, status.tempSummary}, 16'h0000, "limit off");
		check({15'h0, status.overheatWarningFlag}, 16'h0000, "warning off");
		check({15'h0, powerStageOn}, 16'h0001, "no shutdown");
		$display("test cool-down done");
		wrap_up();
	end
endmodule : overtemp_fault_response_tb_top
